// file: core/flow_pkg.sv
// Shared constants, register map and types for the gun supervisor
package flow_pkg;

  // ==========================================================
  // Register map (byte addresses, one 32-bit word each)
  localparam logic [7:0] ADR_CONFIG = 8'h00;
  localparam logic [7:0] ADR_COMMAND = 8'h04;
  localparam logic [7:0] ADR_JOB = 8'h08;
  localparam logic [7:0] ADR_STATUS = 8'h0c;
  localparam logic [7:0] ADR_POT_LIMIT = 8'h10;
  localparam logic [7:0] ADR_MIX_VOL = 8'h14;
  localparam logic [7:0] ADR_REV_LIMIT = 8'h18;
  localparam logic [7:0] ADR_CAL_RATE = 8'h1c;
  localparam logic [7:0] ADR_CAL_TIME = 8'h20;
  localparam logic [7:0] ADR_CAL_SG = 8'h24;
  localparam logic [7:0] ADR_CAL_MEAS = 8'h28;
  localparam logic [7:0] ADR_CAL_PULSES = 8'h2c;
  localparam logic [7:0] ADR_CAL_PPL = 8'h30;

  // ==========================================================
  // Field positions
  localparam int CFG_TWO_COMP = 0;
  localparam int CFG_ASSIGNED = 1;
  localparam int CFG_GUN_CFG = 2;
  localparam int CFG_HORN_EN = 3;
  localparam int CFG_WEIGHT = 4;
  localparam int CMD_CLEAR = 0;
  localparam int CMD_CAL_START = 1;
  localparam int CMD_CAL_STOP = 2;
  localparam int JOB_QUEUED_LSB = 16;
  localparam int JOB_QVALID = 30;
  localparam int JOB_RUNNING = 31;
  localparam int ST_ALARM = 0;
  localparam int ST_CLOSE = 1;
  localparam int ST_HORN = 2;
  localparam int ST_REFUSED = 3;
  localparam int ST_CAL_LSB = 4;

  // ==========================================================
  // Values after reset and fixed figures
  localparam logic [15:0] RST_POT_LIMIT = 16'h0000;
  localparam logic [23:0] RST_MIX_VOL = 24'h000000;
  localparam logic [15:0] RST_REV_LIMIT = 16'h0000;
  localparam logic [15:0] RST_CAL_SG = 16'h03e8;
  localparam logic [15:0] CAL_DOSE_CC = 16'h00c8;
  localparam logic [15:0] CC_PER_LITRE = 16'h03e8;
  localparam int SLOT_COUNT = 40;
  localparam logic [23:0] SLOT_DIVISOR = 24'(SLOT_COUNT);
  localparam logic [15:0] AGE_MIXED = 16'h0001;
  localparam logic [15:0] AGE_MAX = 16'hffff;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    CAL_IDLE = 3'b001,
    CAL_COLLECT = 3'b010,
    CAL_DONE = 3'b100
  } cal_state_t;

  typedef enum logic [1:0] {
    MODE_IDLE = 2'h0,
    MODE_RUN = 2'h1,
    MODE_LOAD = 2'h2,
    MODE_CLEAN = 2'h3
  } gun_mode_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef struct packed {
    logic [SLOT_COUNT-1:0][15:0] slots;
    logic alarm;
  } pot_state_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [4:0] cfg;
    logic [15:0] pot_limit;
    logic [23:0] mix_vol;
    logic [15:0] rev_limit;
    logic [9:0] last_job;
    logic [9:0] cur_job;
    logic [9:0] q_job;
    logic q_valid;
    logic running;
    logic run_d;
    logic halt_d;
    logic [15:0] rev_cnt;
    logic reg_close;
    logic [23:0] slot_acc;
    logic horn;
    logic alarm_d;
    cal_state_t cal;
    logic cal_refused;
    logic [15:0] cal_rate;
    logic [15:0] cal_time;
    logic [15:0] cal_left;
    logic [15:0] cal_sg;
    logic [23:0] cal_pulses;
    logic [31:0] cal_ppl;
  } core_state_t;

endpackage : flow_pkg

// file: core/potlife_window.sv
// Forty-slot material age window that raises the pot-life alarm
`timescale 1ns/1ns
module potlife_window (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic shift,
  input wire logic fill_mixed,
  input wire logic sec_tick,
  input wire logic [15:0] limit,
  output logic alarm
);

  flow_pkg::pot_state_t st_ff;
  flow_pkg::pot_state_t nxt_st;
  logic [flow_pkg::SLOT_COUNT-1:0][15:0] slot_nxt;
  logic [flow_pkg::SLOT_COUNT-1:0] over;

  // ==========================================================
  // Per-slot shift and ageing
  genvar i;
  generate
    for (i = 0; i < flow_pkg::SLOT_COUNT; i++) begin : g_slot
      logic [15:0] src;
      logic fresh;
      // Oldest slot falls off the end; slot 0 takes the new entry
      if (i == 0) begin : g_head
        assign src = shift ? (fill_mixed ? flow_pkg::AGE_MIXED : 16'h0000)
                           : st_ff.slots[0]; // R10 R11 R12
      end else begin : g_body
        assign src = shift ? st_ff.slots[i-1] : st_ff.slots[i]; // R10
      end
      assign fresh = shift && (i == 0);
      // Solvent stays zero; age stops at the top instead of wrapping
      assign slot_nxt[i] = (sec_tick && !fresh && src != 16'h0000 &&
                            src != flow_pkg::AGE_MAX) ? src + 16'h0001
                                                      : src; // R13 R23
      assign over[i] = slot_nxt[i] > limit; // R14
    end
  endgenerate

  // Zero limit disables the check outright
  always_comb begin
    nxt_st = st_ff;
    nxt_st.slots = slot_nxt;
    nxt_st.alarm = (|over) && (limit != 16'h0000); // R14 R15
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign alarm = st_ff.alarm;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_new_slot_mixed: assert property (shift && fill_mixed |=> // R11
    st_ff.slots[0] == flow_pkg::AGE_MIXED)
    else $error("mixed entry not aged one second");
  a_new_slot_solvent: assert property (shift && !fill_mixed |=> // R12
    st_ff.slots[0] == 16'h0000)
    else $error("solvent entry not zero");
  a_slot_age_step: assert property (sec_tick && !shift && // R13
    st_ff.slots[0] != 16'h0000 && st_ff.slots[0] != flow_pkg::AGE_MAX |=>
    st_ff.slots[0] == $past(st_ff.slots[0]) + 16'h0001)
    else $error("slot age did not step");
  a_zero_limit_clear: assert property (limit == 16'h0000 |=> !alarm) // R15
    else $error("alarm with zero limit");

endmodule : potlife_window

// file: core/job_queue_potlife_monitor.sv
// Gun supervisor: job queue, reverse flow, pot life, calibration
//
// How it works
// R1 - Run with empty queue resumes the job number most recently entered.
// R2 - Halt stops the current job; later run restarts the previous job.
// R3 - A newly entered job followed by run restarts with the new job.
// R4 - Trigger never touches the queue; only a run while stopped consumes it.
// R5 - One queue entry; a second entry overwrites the waiting one.
// R6 - Two-component guns count meter flow forward and reverse.
// R7 - Reverse flow past the limit closes the fluid regulators at once.
// R8 - Each two-component gun has its own pot-life limit from the job.
// R9 - Mixed volume split into 40 equal slots of mixed volume over 40.
// R10 - Each slot volume of flow shifts the window, dropping the oldest.
// R11 - New slot in run or load mode starts at one second age.
// R12 - New slot in clean mode starts at zero, meaning solvent.
// R13 - Every second, nonzero slots age by one; zero slots stay zero.
// R14 - Alarm while any slot is older than the pot-life limit.
// R15 - Zero limit clears the alarm; otherwise it holds until flushed.
// R16 - Clear faults silences the horn and releases the regulators, not the alarm; alarm never stops the gun.
// R17 - Horn enable decides horn use; alarm also on a discrete output.
// R18 - Calibration refused for unassigned channel or unconfigured gun.
// R19 - Auto calibration defaults collection time to dispense 200 cc.
// R20 - Collection timed from start; flow stops when the timer expires.
// R21 - Pulses per litre from calibration pulses and measured amount only.
// R22 - Weight calibration converts through entered specific gravity.
// R23 - Slot ages saturate at maximum instead of wrapping.
//
// Implementation choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ns
module job_queue_potlife_monitor (
  input wire logic clk,
  input wire logic reset_n,
  input wire flow_pkg::wb_req_t wb_req,
  output flow_pkg::wb_rsp_t wb_rsp,
  input wire logic run_in,
  input wire logic halt_in,
  input wire flow_pkg::gun_mode_t gun_mode,
  input wire logic fwd_pulse,
  input wire logic rev_pulse,
  input wire logic sec_tick,
  output logic regulator_close,
  output logic cal_flow_en,
  output logic potlife_alarm,
  output logic horn,
  output logic running
);

  flow_pkg::core_state_t st_ff;
  flow_pkg::core_state_t nxt_st;
  logic bus_hit;
  logic bus_wr;
  logic [7:0] word_adr;
  logic [31:0] rd_mux;
  logic [31:0] wr_word;
  logic cmd_wr;
  logic clear_cmd;
  logic start_cmd;
  logic stop_cmd;
  logic job_wr;
  logic run_rise;
  logic halt_rise;
  logic two_comp;
  logic pot_alarm;
  logic slot_shift;
  logic fill_mixed;
  logic [23:0] slot_vol;
  logic [39:0] ppl_num;
  logic [39:0] ppl_quo;

  // Byte lanes replace only the selected bytes of the old value
  function automatic logic [31:0] merge_sel(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge_sel

  // ==========================================================
  // Wishbone decode; ack is registered, so one request per two cycles
  assign bus_hit = wb_req.cyc && wb_req.stb && !st_ff.ack;
  assign bus_wr = bus_hit && wb_req.we;
  assign word_adr = {wb_req.adr[7:2], 2'b00};
  assign wr_word = merge_sel(rd_mux, wb_req.dat, wb_req.sel);
  assign cmd_wr = bus_wr && word_adr == flow_pkg::ADR_COMMAND &&
                  wb_req.sel[0];
  assign clear_cmd = cmd_wr && wb_req.dat[flow_pkg::CMD_CLEAR];
  assign start_cmd = cmd_wr && wb_req.dat[flow_pkg::CMD_CAL_START];
  assign stop_cmd = cmd_wr && wb_req.dat[flow_pkg::CMD_CAL_STOP];
  assign job_wr = bus_wr && word_adr == flow_pkg::ADR_JOB;
  assign two_comp = st_ff.cfg[flow_pkg::CFG_TWO_COMP];

  // Read mux; unmapped words read as zero and still acknowledge
  always_comb begin
    rd_mux = 32'h0;
    case (word_adr)
      flow_pkg::ADR_CONFIG: rd_mux = {27'h0, st_ff.cfg};
      flow_pkg::ADR_JOB: begin
        rd_mux[9:0] = st_ff.cur_job;
        rd_mux[flow_pkg::JOB_QUEUED_LSB +: 10] = st_ff.q_job;
        rd_mux[flow_pkg::JOB_QVALID] = st_ff.q_valid;
        rd_mux[flow_pkg::JOB_RUNNING] = st_ff.running;
      end
      flow_pkg::ADR_STATUS: begin
        rd_mux[flow_pkg::ST_ALARM] = pot_alarm;
        rd_mux[flow_pkg::ST_CLOSE] = st_ff.reg_close;
        rd_mux[flow_pkg::ST_HORN] = st_ff.horn;
        rd_mux[flow_pkg::ST_REFUSED] = st_ff.cal_refused;
        rd_mux[flow_pkg::ST_CAL_LSB +: 3] = st_ff.cal;
      end
      flow_pkg::ADR_POT_LIMIT: rd_mux = {16'h0, st_ff.pot_limit};
      flow_pkg::ADR_MIX_VOL: rd_mux = {8'h0, st_ff.mix_vol};
      flow_pkg::ADR_REV_LIMIT: rd_mux = {16'h0, st_ff.rev_limit};
      flow_pkg::ADR_CAL_RATE: rd_mux = {16'h0, st_ff.cal_rate};
      flow_pkg::ADR_CAL_TIME: rd_mux = {16'h0, st_ff.cal_time};
      flow_pkg::ADR_CAL_SG: rd_mux = {16'h0, st_ff.cal_sg};
      flow_pkg::ADR_CAL_PULSES: rd_mux = {8'h0, st_ff.cal_pulses};
      flow_pkg::ADR_CAL_PPL: rd_mux = st_ff.cal_ppl;
      default: rd_mux = 32'h0;
    endcase
  end

  // ==========================================================
  // Pot-life slot feed
  assign slot_vol = st_ff.mix_vol / flow_pkg::SLOT_DIVISOR; // R9
  // A zero slot volume shifts on every pulse rather than never
  assign slot_shift = two_comp && fwd_pulse &&
                      (st_ff.slot_acc + 24'h000001 >= slot_vol); // R10
  assign fill_mixed = gun_mode == flow_pkg::MODE_RUN ||
                      gun_mode == flow_pkg::MODE_LOAD; // R11 R12

  potlife_window u_window (
    .clk(clk),
    .reset_n(reset_n),
    .shift(slot_shift),
    .fill_mixed(fill_mixed),
    .sec_tick(sec_tick),
    .limit(st_ff.pot_limit),
    .alarm(pot_alarm)
  );

  // Weight mode scales by gravity, volume mode by cc per litre
  assign ppl_num = 40'(st_ff.cal_pulses) *
                   40'(st_ff.cfg[flow_pkg::CFG_WEIGHT] ? st_ff.cal_sg
                       : flow_pkg::CC_PER_LITRE); // R21 R22
  assign ppl_quo = (wr_word[15:0] == 16'h0000) ? 40'h0
                   : ppl_num / 40'(wr_word[15:0]); // R21

  assign run_rise = run_in && !st_ff.run_d;
  assign halt_rise = halt_in && !st_ff.halt_d;

  // ==========================================================
  // Next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ack = bus_hit;
    if (bus_hit && !wb_req.we) begin
      nxt_st.rdata = rd_mux;
    end

    // Register writes
    if (bus_wr) begin
      case (word_adr)
        flow_pkg::ADR_CONFIG: nxt_st.cfg = wr_word[4:0];
        flow_pkg::ADR_POT_LIMIT: nxt_st.pot_limit = wr_word[15:0]; // R8
        flow_pkg::ADR_MIX_VOL: nxt_st.mix_vol = wr_word[23:0];
        flow_pkg::ADR_REV_LIMIT: nxt_st.rev_limit = wr_word[15:0];
        flow_pkg::ADR_CAL_RATE: begin
          nxt_st.cal_rate = wr_word[15:0];
          // Rate write proposes a time; a later time write overrides it
          nxt_st.cal_time = (wr_word[15:0] == 16'h0000) ? 16'h0000
                            : flow_pkg::CAL_DOSE_CC / wr_word[15:0]; // R19
        end
        flow_pkg::ADR_CAL_TIME: nxt_st.cal_time = wr_word[15:0]; // R19
        flow_pkg::ADR_CAL_SG: nxt_st.cal_sg = wr_word[15:0]; // R22
        flow_pkg::ADR_CAL_MEAS: begin
          if (st_ff.cal == flow_pkg::CAL_DONE) begin
            nxt_st.cal_ppl = ppl_quo[31:0]; // R21
          end
        end
        default: nxt_st.rdata = nxt_st.rdata;
      endcase
    end

    // Job entry always lands in the single queue slot
    nxt_st.run_d = run_in;
    nxt_st.halt_d = halt_in;
    if (job_wr) begin
      nxt_st.last_job = wr_word[9:0];
      nxt_st.q_job = wr_word[9:0]; // R5
      nxt_st.q_valid = 1'b1; // R5
    end
    // Halt wins over run; trigger has no path into the queue
    if (halt_rise) begin
      nxt_st.running = 1'b0; // R2
    end else if (run_rise && !st_ff.running) begin
      nxt_st.running = 1'b1; // R4
      if (nxt_st.q_valid) begin
        nxt_st.cur_job = nxt_st.q_job; // R3
        nxt_st.q_valid = 1'b0; // R4
      end else begin
        nxt_st.cur_job = nxt_st.last_job; // R1 R2
      end
    end

    // Forward flow cancels the reverse run; close wins over clear
    if (two_comp && rev_pulse && !fwd_pulse) begin // R6
      if (st_ff.rev_cnt != 16'hffff) begin
        nxt_st.rev_cnt = st_ff.rev_cnt + 16'h0001;
      end
    end else if (two_comp && fwd_pulse && !rev_pulse) begin // R6
      nxt_st.rev_cnt = 16'h0000;
    end
    if (two_comp && rev_pulse && !fwd_pulse &&
        st_ff.rev_cnt >= st_ff.rev_limit) begin
      nxt_st.reg_close = 1'b1; // R7
    end else if (clear_cmd) begin
      nxt_st.reg_close = 1'b0;
      nxt_st.rev_cnt = 16'h0000;
    end

    // Slot volume accumulator
    if (slot_shift) begin
      nxt_st.slot_acc = 24'h000000; // R10
    end else if (two_comp && fwd_pulse) begin
      nxt_st.slot_acc = st_ff.slot_acc + 24'h000001;
    end

    // Horn sounds on a new alarm; clear only silences it
    nxt_st.alarm_d = pot_alarm;
    if (st_ff.cfg[flow_pkg::CFG_HORN_EN] && pot_alarm && !st_ff.alarm_d) begin
      nxt_st.horn = 1'b1; // R17
    end else if (clear_cmd) begin
      nxt_st.horn = 1'b0; // R16
    end

    // Calibration sequencer
    if (st_ff.cal == flow_pkg::CAL_COLLECT) begin
      if (fwd_pulse && st_ff.cal_pulses != 24'hffffff) begin
        nxt_st.cal_pulses = st_ff.cal_pulses + 24'h000001; // R21
      end
      if (stop_cmd || st_ff.cal_left == 16'h0000) begin
        nxt_st.cal = flow_pkg::CAL_DONE;
      end else if (sec_tick) begin
        nxt_st.cal_left = st_ff.cal_left - 16'h0001; // R20
        if (st_ff.cal_left == 16'h0001) begin
          nxt_st.cal = flow_pkg::CAL_DONE; // R20
        end
      end
    end else if (start_cmd) begin
      if (st_ff.cfg[flow_pkg::CFG_ASSIGNED] &&
          st_ff.cfg[flow_pkg::CFG_GUN_CFG]) begin
        nxt_st.cal = flow_pkg::CAL_COLLECT; // R20
        nxt_st.cal_left = st_ff.cal_time; // R20
        nxt_st.cal_pulses = 24'h000000;
        nxt_st.cal_refused = 1'b0;
      end else begin
        nxt_st.cal_refused = 1'b1; // R18
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
      st_ff.pot_limit <= flow_pkg::RST_POT_LIMIT;
      st_ff.mix_vol <= flow_pkg::RST_MIX_VOL;
      st_ff.rev_limit <= flow_pkg::RST_REV_LIMIT;
      st_ff.cal_sg <= flow_pkg::RST_CAL_SG;
      st_ff.cal <= flow_pkg::CAL_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Pot-life alarm never feeds back into running or flow
  assign wb_rsp.ack = st_ff.ack;
  assign wb_rsp.dat = st_ff.rdata;
  assign regulator_close = st_ff.reg_close;
  assign cal_flow_en = st_ff.cal == flow_pkg::CAL_COLLECT; // R20
  assign potlife_alarm = pot_alarm; // R16 R17
  assign horn = st_ff.horn;
  assign running = st_ff.running;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_idle_run;
    run_rise && !halt_rise && !st_ff.running && !job_wr;
  endsequence
  sequence s_alarm_new;
    st_ff.cfg[flow_pkg::CFG_HORN_EN] && pot_alarm && !st_ff.alarm_d;
  endsequence
  sequence s_cal_last_sec;
    st_ff.cal == flow_pkg::CAL_COLLECT && sec_tick && !stop_cmd &&
    st_ff.cal_left == 16'h0001;
  endsequence

  a_halt_stops_run: assert property (halt_rise |=> !running) // R2
    else $error("halt did not stop the gun");
  a_resume_last_job: assert property (s_idle_run ##0 !st_ff.q_valid |=> // R1
    running && st_ff.cur_job == $past(st_ff.last_job))
    else $error("empty queue run did not resume last job");
  a_queue_new_job: assert property (s_idle_run ##0 st_ff.q_valid |=> // R3
    st_ff.cur_job == $past(st_ff.q_job) && !st_ff.q_valid)
    else $error("queued job not taken on run");
  a_queue_overwrite: assert property (job_wr && !run_rise |=> // R5
    st_ff.q_valid && st_ff.q_job == $past(wr_word[9:0]))
    else $error("queue entry not replaced");
  // Close is sticky; only a clear faults command may release it later
  a_reverse_close: assert property (two_comp && rev_pulse && // R7
    !fwd_pulse && st_ff.rev_cnt >= st_ff.rev_limit |=> regulator_close ##1
    (regulator_close || $past(clear_cmd)))
    else $error("reverse flow did not close regulators");
  // A shift in the same cycle may flush the alarm legitimately
  a_horn_silence: assert property (clear_cmd && !slot_shift && // R16
    !(st_ff.cfg[flow_pkg::CFG_HORN_EN] && pot_alarm && !st_ff.alarm_d) &&
    pot_alarm |=> !horn && potlife_alarm)
    else $error("clear faults wrong on horn or alarm");
  a_alarm_horn: assert property (s_alarm_new |=> horn) // R17
    else $error("enabled horn did not sound");
  a_cal_refuse: assert property (start_cmd && // R18
    st_ff.cal != flow_pkg::CAL_COLLECT && !(st_ff.cfg[flow_pkg::CFG_ASSIGNED]
    && st_ff.cfg[flow_pkg::CFG_GUN_CFG]) |=> !cal_flow_en &&
    st_ff.cal_refused)
    else $error("calibration not refused");
  a_cal_expire: assert property (s_cal_last_sec |=> !cal_flow_en && // R20
    st_ff.cal == flow_pkg::CAL_DONE)
    else $error("flow not stopped at timer expiry");

endmodule : job_queue_potlife_monitor

// file: verif/plc_model.sv
// Host controller model driving run, halt, mode, meter and tick inputs
`timescale 1ns/1ns
module plc_model (
  input wire logic clk,
  output logic run_in,
  output logic halt_in,
  output flow_pkg::gun_mode_t gun_mode,
  output logic fwd_pulse,
  output logic rev_pulse,
  output logic sec_tick
);
  // ==========================================================
  // Idle levels
  // Everything quiet from time zero so reset sees no stray edges
  initial begin
    run_in = 1'b0;
    halt_in = 1'b0;
    gun_mode = flow_pkg::MODE_IDLE;
    fwd_pulse = 1'b0;
    rev_pulse = 1'b0;
    sec_tick = 1'b0;
  end

  // ==========================================================
  // Operator actions
  // Run or halt held two cycles, then released two cycles
  task automatic press(input bit h);
    if (h) begin
      halt_in <= 1'b1;
    end else begin
      run_in <= 1'b1;
    end
    repeat (2) @(posedge clk);
    run_in <= 1'b0;
    halt_in <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : press

  // Mode is a level; one edge lets it land before any pulse
  task automatic set_mode(input flow_pkg::gun_mode_t m);
    gun_mode <= m;
    @(posedge clk);
  endtask : set_mode

  // One-cycle pulses with a gap: kind 0 forward, 1 reverse, 2 tick
  task automatic pulse(input int kind, input int n);
    repeat (n) begin
      fwd_pulse <= (kind == 0);
      rev_pulse <= (kind == 1);
      sec_tick <= (kind == 2);
      @(posedge clk);
      fwd_pulse <= 1'b0;
      rev_pulse <= 1'b0;
      sec_tick <= 1'b0;
      @(posedge clk);
    end
    // Registered outputs trail the last pulse by up to two edges
    repeat (2) @(posedge clk);
  endtask : pulse
endmodule : plc_model

// file: verif/job_queue_potlife_monitor_tb.sv
// Self-checking bench for the gun supervisor
`timescale 1ns/1ns
module job_queue_potlife_monitor_tb;
  logic clk;
  logic reset_n;
  flow_pkg::wb_req_t wb_req;
  flow_pkg::wb_rsp_t wb_rsp;
  logic run_in;
  logic halt_in;
  flow_pkg::gun_mode_t gun_mode;
  logic fwd_pulse;
  logic rev_pulse;
  logic sec_tick;
  logic regulator_close;
  logic cal_flow_en;
  logic potlife_alarm;
  logic horn;
  logic running;
  int bad_count;
  int total_checks;

  job_queue_potlife_monitor dut_u (.clk(clk), .reset_n(reset_n),
    .wb_req(wb_req), .wb_rsp(wb_rsp), .run_in(run_in), .halt_in(halt_in),
    .gun_mode(gun_mode), .fwd_pulse(fwd_pulse), .rev_pulse(rev_pulse),
    .sec_tick(sec_tick), .regulator_close(regulator_close),
    .cal_flow_en(cal_flow_en), .potlife_alarm(potlife_alarm),
    .horn(horn), .running(running));

  plc_model plc_u (.clk(clk), .run_in(run_in), .halt_in(halt_in),
    .gun_mode(gun_mode), .fwd_pulse(fwd_pulse), .rev_pulse(rev_pulse),
    .sec_tick(sec_tick));

  // ==========================================================
  // Clock and reporting
  always #4 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      bad_count++;
    end
  endtask : check

  task automatic print_verdict();
    if (bad_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  // ==========================================================
  // Register bus
  // Request held until ack is sampled; bounded so a dead slave cannot hang
  task automatic xfer(input logic we, input logic [7:0] adr,
                      input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: wd};
    do begin
      @(posedge clk);
      n++;
    end while (wb_rsp.ack !== 1'b1 && n < 50);
    check(32'(wb_rsp.ack), 32'h1);
    rd = wb_rsp.dat;
    wb_req <= '0;
    @(posedge clk);
  endtask : xfer

  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    logic [31:0] unused;
    xfer(1'b1, adr, d, unused);
  endtask : wr

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] mask,
                        input logic [31:0] exp);
    logic [31:0] rd;
    xfer(1'b0, adr, 32'h0, rd);
    check(rd & mask, exp);
  endtask : rd_chk

  // ==========================================================
  // Scenarios
  task automatic test_reset_values();
    rd_chk(flow_pkg::ADR_POT_LIMIT, 32'hffffffff, 32'h0);
    rd_chk(flow_pkg::ADR_CAL_SG, 32'hffffffff, 32'h3e8);
    rd_chk(flow_pkg::ADR_STATUS, 32'h7f, 32'h10);
    rd_chk(8'h3c, 32'hffffffff, 32'h0);
  endtask : test_reset_values

  // Resume, restart and overwrite of the one-entry queue
  task automatic test_job_queue();
    wr(flow_pkg::ADR_JOB, 32'h5);
    plc_u.press(1'b0);
    rd_chk(flow_pkg::ADR_JOB, 32'hc00003ff, 32'h80000005);
    plc_u.press(1'b1);
    check(32'(running), 32'h0);
    plc_u.press(1'b0);
    rd_chk(flow_pkg::ADR_JOB, 32'hc00003ff, 32'h80000005);
    wr(flow_pkg::ADR_JOB, 32'h7);
    wr(flow_pkg::ADR_JOB, 32'h9);
    rd_chk(flow_pkg::ADR_JOB, 32'hc3ff03ff, 32'hc0090005);
    plc_u.press(1'b1);
    plc_u.press(1'b0);
    rd_chk(flow_pkg::ADR_JOB, 32'hc00003ff, 32'h80000009);
  endtask : test_job_queue

  // Limit of two: the third reverse pulse is the first beyond it
  task automatic test_reverse_flow();
    wr(flow_pkg::ADR_CONFIG, 32'h1);
    wr(flow_pkg::ADR_REV_LIMIT, 32'h2);
    plc_u.pulse(1, 2);
    check(32'(regulator_close), 32'h0);
    plc_u.pulse(1, 1);
    check(32'(regulator_close), 32'h1);
    wr(flow_pkg::ADR_COMMAND, 32'h1);
    check(32'(regulator_close), 32'h0);
  endtask : test_reverse_flow

  // One pulse per slot, so exactly forty clean pulses flush an aged slot
  task automatic test_pot_life();
    wr(flow_pkg::ADR_CONFIG, 32'h9);
    wr(flow_pkg::ADR_MIX_VOL, 32'h28);
    wr(flow_pkg::ADR_POT_LIMIT, 32'h2);
    plc_u.set_mode(flow_pkg::MODE_RUN);
    plc_u.pulse(0, 1);
    plc_u.set_mode(flow_pkg::MODE_IDLE);
    plc_u.pulse(2, 1);
    check(32'(potlife_alarm), 32'h0);
    plc_u.pulse(2, 1);
    check(32'(potlife_alarm), 32'h1);
    check(32'(horn), 32'h1);
    wr(flow_pkg::ADR_COMMAND, 32'h1);
    check(32'({horn, potlife_alarm, running}), 32'h3);
    wr(flow_pkg::ADR_POT_LIMIT, 32'h0);
    check(32'(potlife_alarm), 32'h0);
    wr(flow_pkg::ADR_POT_LIMIT, 32'h2);
    plc_u.set_mode(flow_pkg::MODE_CLEAN);
    plc_u.pulse(0, 39);
    check(32'(potlife_alarm), 32'h1);
    plc_u.pulse(0, 1);
    check(32'(potlife_alarm), 32'h0);
    plc_u.pulse(2, 2);
    check(32'(potlife_alarm), 32'h0);
    plc_u.set_mode(flow_pkg::MODE_LOAD);
    plc_u.pulse(0, 1);
    plc_u.pulse(2, 2);
    check(32'(potlife_alarm), 32'h1);
    plc_u.set_mode(flow_pkg::MODE_IDLE);
  endtask : test_pot_life

  // Refusal, timed volume run, then a weight run ended by stop
  task automatic test_calibration();
    wr(flow_pkg::ADR_CONFIG, 32'h0);
    wr(flow_pkg::ADR_COMMAND, 32'h2);
    rd_chk(flow_pkg::ADR_STATUS, 32'h78, 32'h18);
    wr(flow_pkg::ADR_CONFIG, 32'h6);
    wr(flow_pkg::ADR_CAL_RATE, 32'h32);
    rd_chk(flow_pkg::ADR_CAL_TIME, 32'hffff, 32'h4);
    wr(flow_pkg::ADR_COMMAND, 32'h2);
    check(32'(cal_flow_en), 32'h1);
    plc_u.pulse(0, 10);
    plc_u.pulse(2, 3);
    check(32'(cal_flow_en), 32'h1);
    plc_u.pulse(2, 1);
    check(32'(cal_flow_en), 32'h0);
    rd_chk(flow_pkg::ADR_CAL_PULSES, 32'hffffff, 32'ha);
    wr(flow_pkg::ADR_CAL_MEAS, 32'h5);
    rd_chk(flow_pkg::ADR_CAL_PPL, 32'hffffffff, 32'h7d0);
    wr(flow_pkg::ADR_CONFIG, 32'h16);
    wr(flow_pkg::ADR_CAL_SG, 32'h1f4);
    wr(flow_pkg::ADR_COMMAND, 32'h2);
    plc_u.pulse(0, 10);
    wr(flow_pkg::ADR_COMMAND, 32'h4);
    check(32'(cal_flow_en), 32'h0);
    wr(flow_pkg::ADR_CAL_MEAS, 32'h5);
    rd_chk(flow_pkg::ADR_CAL_PPL, 32'hffffffff, 32'h3e8);
  endtask : test_calibration

  // ==========================================================
  // Main sequence
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    wb_req = '0;
    bad_count = 0;
    total_checks = 0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    test_reset_values();
    test_job_queue();
    test_reverse_flow();
    test_pot_life();
    test_calibration();
    print_verdict();
  end

  // Watchdog: the whole sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    print_verdict();
  end
endmodule : job_queue_potlife_monitor_tb
